// >>> p2b_ctrl_regs.v
/*
 basic control and basic status register pair of the port 2
 transceiver, plus the control four and status alias registers whose
 aliased bits share storage with them. drives the transceiver control lines
 and hands the forced settings to the mode resolver, whose registered
 speed and duplex come back out as the resolved mode.
 every aliased bit is one flip-flop: a write through either address
 lands in the same element, and both addresses read it back, so the
 two views can never drift apart.
 the restart bit is the only self-clearing bit; it reads one only in
 the cycle after the write that set it.
 reserved, unsupported and unmapped bits read zero and ignore writes;
 the basic status register is read-only as a whole.
 the far-end-fault status is masked by fiber mode and by its detect
 disable bit, so a copper port always reads it clear.
 assumes a plain register port: one-cycle read or write strobes, never
 both at once, read data in the following cycle only, and zero
 otherwise.
 assumes the status inputs are synchronous to clk_sys and stable for
 the cycle in which a read strobe is sampled.
 assumes a synchronous active-low reset held for at least one edge.
*/
// Design decision made here: the plain strobed port.
`include "p2b_defines.vh"

module p2b_ctrl_regs (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // register port
  input wire [`P2B_AW-1:0] reg_addr,
  input wire [`P2B_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`P2B_DW-1:0] reg_rdata,
  // transceiver status
  input wire an_complete,
  input wire an_failed,
  input wire an_res_100,
  input wire an_res_full,
  input wire link_up,
  input wire far_fault,
  input wire fiber_mode,
  input wire [4:0] lp_ability,
  // transceiver control
  output wire far_loopback,
  output wire force_100,
  output wire an_enable,
  output wire power_down,
  output wire an_restart,
  output wire force_full,
  output wire xover_alg_sel,
  output wire force_mdix,
  output wire mdix_disable,
  output wire fef_detect_en,
  output wire tx_disable,
  output wire [4:0] adv_ability,
  // resolved mode
  output wire op_speed_100,
  output wire op_full_duplex
);

  // shared storage, one element per aliased bit, plus the unaliased advertisement bits
  reg flb_r;
  reg spd_r;
  reg ane_r;
  reg pd_r;
  reg fd_r;
  reg xalg_r;
  reg fmdix_r;
  reg dmdix_r;
  reg dfef_r;
  reg dtx_r;
  reg [4:0] adv_r;

  // restart pulse and its set request
  wire rst_bit;
  wire restart_set;

  // read mux output
  reg [`P2B_DW-1:0] rd_mux;

  // read data before its register
  reg [`P2B_DW-1:0] rdata_nxt;

  // address decode
  wire sel_ctrl;
  wire sel_stat;
  wire sel_cr4;
  wire sel_sr;

  // write strobes
  wire wr_ctrl;
  wire wr_cr4;
  wire wr_sr;

  // qualified status
  wire fef_seen;

  assign sel_ctrl = (reg_addr == `P2B_OFS_CTRL);
  assign sel_stat = (reg_addr == `P2B_OFS_STAT);
  assign sel_cr4 = (reg_addr == `P2B_OFS_CR4);
  assign sel_sr = (reg_addr == `P2B_OFS_SR);

  // write strobes, one per writable address
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign wr_cr4 = reg_wr & sel_cr4;
  assign wr_sr = reg_wr & sel_sr;

  // far-end loopback, written through either alias
  always @(posedge clk_sys) begin
    if (!nrst) begin
      flb_r <= `P2B_RST_FLB;
    end else if (wr_ctrl) begin
      flb_r <= reg_wdata[`P2B_C_FLB]; // R1
    end else if (wr_cr4) begin
      flb_r <= reg_wdata[`P2B_F_FLB]; // R20
    end
  end

  // forced speed
  always @(posedge clk_sys) begin
    if (!nrst) begin
      spd_r <= `P2B_RST_SPD; // R2
    end else if (wr_ctrl) begin
      spd_r <= reg_wdata[`P2B_C_SPD];
    end else if (wr_cr4) begin
      spd_r <= reg_wdata[`P2B_F_SPD]; // R20
    end
  end

  // negotiation enable
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ane_r <= `P2B_RST_ANE; // R3
    end else if (wr_ctrl) begin
      ane_r <= reg_wdata[`P2B_C_ANE]; // R3
    end else if (wr_cr4) begin
      ane_r <= reg_wdata[`P2B_F_ANE]; // R20
    end
  end

  // power-down
  always @(posedge clk_sys) begin
    if (!nrst) begin
      pd_r <= `P2B_RST_PD; // R4
    end else if (wr_ctrl) begin
      pd_r <= reg_wdata[`P2B_C_PD]; // R4
    end else if (wr_cr4) begin
      pd_r <= reg_wdata[`P2B_F_PD]; // R20
    end
  end

  // forced duplex
  always @(posedge clk_sys) begin
    if (!nrst) begin
      fd_r <= `P2B_RST_FD; // R6
    end else if (wr_ctrl) begin
      fd_r <= reg_wdata[`P2B_C_FD];
    end else if (wr_cr4) begin
      fd_r <= reg_wdata[`P2B_F_FD]; // R20
    end
  end

  // crossover algorithm, its alias sits in the status alias register
  always @(posedge clk_sys) begin
    if (!nrst) begin
      xalg_r <= `P2B_RST_XALG; // R8
    end else if (wr_ctrl) begin
      xalg_r <= reg_wdata[`P2B_C_XALG]; // R8
    end else if (wr_sr) begin
      xalg_r <= reg_wdata[`P2B_A_XALG]; // R20
    end
  end

  // forced crossed pin assignment
  always @(posedge clk_sys) begin
    if (!nrst) begin
      fmdix_r <= `P2B_RST_FMDIX;
    end else if (wr_ctrl) begin
      fmdix_r <= reg_wdata[`P2B_C_FMDIX]; // R9
    end else if (wr_cr4) begin
      fmdix_r <= reg_wdata[`P2B_F_FMDIX]; // R20
    end
  end

  // automatic crossover disable
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dmdix_r <= `P2B_RST_DMDIX;
    end else if (wr_ctrl) begin
      dmdix_r <= reg_wdata[`P2B_C_DMDIX]; // R10
    end else if (wr_cr4) begin
      dmdix_r <= reg_wdata[`P2B_F_DMDIX]; // R20
    end
  end

  // far-end-fault detection disable
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dfef_r <= `P2B_RST_DFEF;
    end else if (wr_ctrl) begin
      dfef_r <= reg_wdata[`P2B_C_DFEF]; // R11
    end else if (wr_cr4) begin
      dfef_r <= reg_wdata[`P2B_F_DFEF]; // R20
    end
  end

  // transmit disable
  always @(posedge clk_sys) begin
    if (!nrst) begin
      dtx_r <= `P2B_RST_DTX; // R12
    end else if (wr_ctrl) begin
      dtx_r <= reg_wdata[`P2B_C_DTX]; // R12
    end else if (wr_cr4) begin
      dtx_r <= reg_wdata[`P2B_F_DTX]; // R20
    end
  end

  // advertisement bits, reachable here only through control four
  always @(posedge clk_sys) begin
    if (!nrst) begin
      adv_r <= `P2B_RST_ADV;
    end else if (wr_cr4) begin
      adv_r <= reg_wdata[`P2B_F_ADV_HI:`P2B_F_ADV_LO];
    end
  end

  // restart request, from whichever alias is written
  assign restart_set = (wr_ctrl & reg_wdata[`P2B_C_RST]) |
                       (wr_cr4 & reg_wdata[`P2B_F_RST]); // R5

  // restart is self-clearing; either alias may trigger it
  p2b_restart_pulse u_restart (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .set_req(restart_set), // R5
    .bit_r(rst_bit)
  );

  // speed and duplex the transceiver actually runs at
  p2b_mode_resolve u_mode (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .an_enable(ane_r),
    .force_100(spd_r),
    .force_full(fd_r),
    .an_complete(an_complete),
    .an_failed(an_failed),
    .an_res_100(an_res_100),
    .an_res_full(an_res_full),
    .op_100_r(op_speed_100),
    .op_full_r(op_full_duplex)
  );

  // fault only means something on fiber; copper reads it as clear
  assign fef_seen = fiber_mode & far_fault & ~dfef_r; // R16

  // control lines straight from storage, except fef_detect_en, which is also gated by fiber_mode
  assign far_loopback = flb_r; // R1
  assign force_100 = spd_r; // R2
  assign an_enable = ane_r; // R3
  assign power_down = pd_r; // R4
  assign an_restart = rst_bit; // R5
  assign force_full = fd_r; // R6
  assign xover_alg_sel = xalg_r; // R8
  assign force_mdix = fmdix_r; // R9
  assign mdix_disable = dmdix_r; // R10
  assign fef_detect_en = fiber_mode & ~dfef_r; // R11
  assign tx_disable = dtx_r; // R12
  assign adv_ability = adv_r;

  // read mux; unsupported and reserved bits stay zero
  always @* begin
    rd_mux = `P2B_ZERO; // R13 R19
    case (1'h1)
      sel_ctrl: begin
        rd_mux[`P2B_C_FLB] = flb_r;
        rd_mux[`P2B_C_SPD] = spd_r;
        rd_mux[`P2B_C_ANE] = ane_r;
        rd_mux[`P2B_C_PD] = pd_r;
        rd_mux[`P2B_C_RST] = rst_bit;
        rd_mux[`P2B_C_FD] = fd_r;
        rd_mux[`P2B_C_XALG] = xalg_r;
        rd_mux[`P2B_C_FMDIX] = fmdix_r;
        rd_mux[`P2B_C_DMDIX] = dmdix_r;
        rd_mux[`P2B_C_DFEF] = dfef_r;
        rd_mux[`P2B_C_DTX] = dtx_r;
      end
      sel_stat: begin
        rd_mux[`P2B_S_T4] = `P2B_NIL; // R14
        rd_mux[`P2B_S_TXF] = `P2B_ONE; // R14
        rd_mux[`P2B_S_TXH] = `P2B_ONE;
        rd_mux[`P2B_S_TF] = `P2B_ONE;
        rd_mux[`P2B_S_TH] = `P2B_ONE;
        rd_mux[`P2B_S_ANC] = an_complete; // R15
        rd_mux[`P2B_S_FEF] = fef_seen; // R16
        rd_mux[`P2B_S_ANA] = `P2B_ONE; // R17
        rd_mux[`P2B_S_LNK] = link_up; // R18
      end
      sel_cr4: begin
        rd_mux[`P2B_F_DTX] = dtx_r;
        rd_mux[`P2B_F_RST] = rst_bit;
        rd_mux[`P2B_F_DFEF] = dfef_r;
        rd_mux[`P2B_F_PD] = pd_r;
        rd_mux[`P2B_F_DMDIX] = dmdix_r;
        rd_mux[`P2B_F_FMDIX] = fmdix_r;
        rd_mux[`P2B_F_FLB] = flb_r;
        rd_mux[`P2B_F_ANE] = ane_r;
        rd_mux[`P2B_F_SPD] = spd_r;
        rd_mux[`P2B_F_FD] = fd_r;
        rd_mux[`P2B_F_ADV_HI:`P2B_F_ADV_LO] = adv_r;
      end
      sel_sr: begin
        rd_mux[`P2B_A_XALG] = xalg_r; // R20
        rd_mux[`P2B_A_FEF] = fef_seen; // R20
        rd_mux[`P2B_A_ANC] = an_complete;
        rd_mux[`P2B_A_LNK] = link_up;
        rd_mux[`P2B_A_LP_HI:`P2B_A_LP_LO] = lp_ability;
      end
      default: begin
        rd_mux = `P2B_ZERO;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @* begin
    rdata_nxt = `P2B_ZERO;
    if (reg_rd) begin
      rdata_nxt = rd_mux;
    end
  end

  // read data register
  always @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= `P2B_ZERO;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

endmodule

// >>> p2b_defines.vh
/*
 constants for the port 2 transceiver basic control and status bank:
 register byte offsets, bit positions inside each register and reset
 values. assumes a 12-bit byte address and 16-bit register data.
*/
//
// Overview of operation
// R1: far-end loopback bit loops port 1 traffic
// R2: speed bit forces 100 or 10, resets 1
// R3: negotiation enable bit, resets enabled
// R4: power-down bit powers transceiver down, resets 0
// R5: restart bit restarts negotiation, self-clears
// R6: duplex bit forces full/half when negotiation off
// R7: failed negotiation always gives half duplex
// R8: crossover algorithm select, resets 1
// R9: force-crossover bit forces crossed pin assignment
// R10: crossover-disable bit stops automatic detection
// R11: fault-detect disable bit, fiber mode only
// R12: transmit-disable bit stops transmission, resets 0
// R13: isolate and collision-test bits read 0
// R14: capability bits constant, T4 reads 0
// R15: negotiation-complete status bit
// R16: far-end-fault status bit in fiber mode
// R17: negotiation-capable bit always reads 1
// R18: link status bit follows link
// R19: extended, preamble, jabber bits read 0
// R20: aliased bits share one storage element
`ifndef P2B_DEFINES_VH
`define P2B_DEFINES_VH

// bus shape
`define P2B_AW 12
`define P2B_DW 16
`define P2B_ZERO 16'h0000

// register byte offsets
`define P2B_OFS_CTRL 12'h058
`define P2B_OFS_STAT 12'h05A
`define P2B_OFS_CR4 12'h080
`define P2B_OFS_SR 12'h082

// basic control bit positions
`define P2B_C_FLB 14
`define P2B_C_SPD 13
`define P2B_C_ANE 12
`define P2B_C_PD 11
`define P2B_C_RST 9
`define P2B_C_FD 8
`define P2B_C_XALG 5
`define P2B_C_FMDIX 4
`define P2B_C_DMDIX 3
`define P2B_C_DFEF 2
`define P2B_C_DTX 1

// basic status bit positions
`define P2B_S_T4 15
`define P2B_S_TXF 14
`define P2B_S_TXH 13
`define P2B_S_TF 12
`define P2B_S_TH 11
`define P2B_S_ANC 5
`define P2B_S_FEF 4
`define P2B_S_ANA 3
`define P2B_S_LNK 2

// control four bit positions
`define P2B_F_DTX 14
`define P2B_F_RST 13
`define P2B_F_DFEF 12
`define P2B_F_PD 11
`define P2B_F_DMDIX 10
`define P2B_F_FMDIX 9
`define P2B_F_FLB 8
`define P2B_F_ANE 7
`define P2B_F_SPD 6
`define P2B_F_FD 5
`define P2B_F_ADV_HI 4
`define P2B_F_ADV_LO 0

// status alias bit positions
`define P2B_A_XALG 15
`define P2B_A_FEF 8
`define P2B_A_ANC 6
`define P2B_A_LNK 5
`define P2B_A_LP_HI 4
`define P2B_A_LP_LO 0

// reset values
`define P2B_RST_FLB 1'h0
`define P2B_RST_SPD 1'h1
`define P2B_RST_ANE 1'h1
`define P2B_RST_PD 1'h0
`define P2B_RST_FD 1'h1
`define P2B_RST_XALG 1'h1
`define P2B_RST_FMDIX 1'h0
`define P2B_RST_DMDIX 1'h0
`define P2B_RST_DFEF 1'h0
`define P2B_RST_DTX 1'h0
`define P2B_RST_ADV 5'h1F
`define P2B_ONE 1'h1
`define P2B_NIL 1'h0

`endif

// >>> p2b_restart_pulse.v
/*
 self-clearing restart-negotiation bit. a write of one sets the bit,
 which then clears on the next edge; the bit itself is the pulse.
 assumes the set strobe is one cycle long.
*/
`include "p2b_defines.vh"

module p2b_restart_pulse (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // set request
  input wire set_req,
  // bit state, also the restart pulse
  output reg bit_r
);

  reg bit_nxt;

  // set wins over the self-clear, so back-to-back writes keep it high
  always @* begin
    bit_nxt = `P2B_NIL;
    if (set_req) begin
      bit_nxt = `P2B_ONE; // R5
    end
  end

  // bit lives exactly one cycle after each write of one
  always @(posedge clk_sys) begin
    if (!nrst) begin
      bit_r <= `P2B_NIL;
    end else begin
      bit_r <= bit_nxt;
    end
  end

endmodule

// >>> p2b_mode_resolve.v
/*
 resolves the operating speed and duplex of the port 2 transceiver
 from the forced settings and the negotiation outcome.
 assumes the negotiation inputs are synchronous to clk_sys.
*/
`include "p2b_defines.vh"

module p2b_mode_resolve (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // forced settings
  input wire an_enable,
  input wire force_100,
  input wire force_full,
  // negotiation outcome
  input wire an_complete,
  input wire an_failed,
  input wire an_res_100,
  input wire an_res_full,
  // resolved mode
  output reg op_100_r,
  output reg op_full_r
);

  reg op_100_nxt;
  reg op_full_nxt;

  // forced values only count while negotiation is off
  always @* begin
    op_100_nxt = force_100; // R2
    op_full_nxt = force_full; // R6
    if (an_enable) begin
      op_100_nxt = an_res_100;
      // a failed or unfinished negotiation never claims full duplex
      op_full_nxt = an_complete & an_res_full & ~an_failed; // R7
    end
  end

  // registered so the mode outputs never glitch
  always @(posedge clk_sys) begin
    if (!nrst) begin
      op_100_r <= `P2B_RST_SPD;
      op_full_r <= `P2B_NIL;
    end else begin
      op_100_r <= op_100_nxt;
      op_full_r <= op_full_nxt;
    end
  end

endmodule

// >>> p2b_ctrl_regs_checker.sv
/*
 port-level assertions for the port 2 basic control and status bank.
 assumes one clock domain and a synchronous active-low reset.
*/
`include "p2b_defines.vh"

module p2b_ctrl_regs_checker (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // register port
  input wire [`P2B_AW-1:0] reg_addr,
  input wire [`P2B_DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [`P2B_DW-1:0] reg_rdata,
  // transceiver status
  input wire an_complete,
  input wire an_failed,
  input wire link_up,
  input wire fiber_mode,
  // transceiver control
  input wire far_loopback,
  input wire force_100,
  input wire an_enable,
  input wire an_restart,
  input wire force_full,
  input wire fef_detect_en,
  input wire op_speed_100,
  input wire op_full_duplex
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // decoded strobes; restart may be set through either alias
  wire wr_c = reg_wr && reg_addr == `P2B_OFS_CTRL;
  wire wr_f = reg_wr && reg_addr == `P2B_OFS_CR4;
  wire rs_set = (wr_c && reg_wdata[9]) || (wr_f && reg_wdata[13]);

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_restart_pulse: assert property (rs_set |=> an_restart)
    else $error("restart pulse missing");
  a_restart_clears: assert property (an_restart && !rs_set |=> !an_restart)
    else $error("restart bit did not self clear");
  a_loop_write: assert property (wr_c |=> far_loopback == $past(reg_wdata[14]))
    else $error("loopback output wrong after write");
  a_alias_write: assert property (wr_f |=> force_100 == $past(reg_wdata[6])
    && an_enable == $past(reg_wdata[7]))
    else $error("alias write not seen on outputs");
  a_forced_mode: assert property (!an_enable |=> op_speed_100 == $past(force_100)
    && op_full_duplex == $past(force_full))
    else $error("forced mode not applied");
  a_failed_half: assert property (an_enable && an_failed |=> !op_full_duplex)
    else $error("failed negotiation not half duplex");
  a_fef_gate: assert property (!fiber_mode |-> !fef_detect_en)
    else $error("fault detect active outside fiber mode");
  a_status_read: assert property (reg_rd && reg_addr == `P2B_OFS_STAT |=>
    reg_rdata[15:6] == 10'h1E0 && reg_rdata[3] && reg_rdata[1:0] == 2'h0
    && reg_rdata[5] == $past(an_complete) && reg_rdata[2] == $past(link_up))
    else $error("status read wrong");
  a_ctrl_ro_zero: assert property (reg_rd && reg_addr == `P2B_OFS_CTRL |=>
    reg_rdata[15] == 1'h0 && reg_rdata[10] == 1'h0 && reg_rdata[7:6] == 2'h0
    && reg_rdata[0] == 1'h0)
    else $error("read-only control bits not zero");

  c_restart: cover property (rs_set ##1 an_restart);
  c_link_read: cover property (reg_rd && reg_addr == `P2B_OFS_STAT && link_up);
  c_failed: cover property (an_enable && an_failed);
endmodule

bind p2b_ctrl_regs p2b_ctrl_regs_checker p2b_ctrl_regs_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .an_complete(an_complete),
  .an_failed(an_failed), .link_up(link_up), .fiber_mode(fiber_mode),
  .far_loopback(far_loopback), .force_100(force_100), .an_enable(an_enable),
  .an_restart(an_restart), .force_full(force_full), .fef_detect_en(fef_detect_en),
  .op_speed_100(op_speed_100), .op_full_duplex(op_full_duplex));

// >>> p2b_ctrl_regs_bench.sv
/*
 self-checking bench for the port 2 basic control and status bank.
 assumes the bench is the top and the checker is bound to the bank.
*/
module p2b_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, nrst, reg_wr, reg_rd;
  logic [11:0] reg_addr, st;
  logic [15:0] reg_wdata, reg_rdata, m_ctrl;
  logic [4:0] m_adv, adv_ability;
  logic far_loopback, force_100, an_enable, power_down, an_restart, force_full;
  logic xover_alg_sel, force_mdix, mdix_disable, fef_detect_en, tx_disable;
  logic op_speed_100, op_full_duplex;
  logic [31:0] rng;
  int err_count, comparisons, cycles, i;
  // alias pairs: basic control bit and its control four position
  int bp[9] = '{1, 2, 11, 3, 4, 14, 12, 13, 8};
  int fp[9] = '{14, 12, 11, 10, 9, 8, 7, 6, 5};
  // odd and unmapped places mixed in to hit the refusal paths
  logic [11:0] at[8] = '{12'h058, 12'h05A, 12'h080, 12'h082, 12'h058, 12'h080, 12'h059, 12'h0FE};

  p2b_ctrl_regs p2b_ctrl_regs_inst (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .an_complete(st[11]), .an_failed(st[10]), .an_res_100(st[9]), .an_res_full(st[8]),
    .link_up(st[7]), .far_fault(st[6]), .fiber_mode(st[5]), .lp_ability(st[4:0]),
    .far_loopback(far_loopback), .force_100(force_100), .an_enable(an_enable),
    .power_down(power_down), .an_restart(an_restart), .force_full(force_full),
    .xover_alg_sel(xover_alg_sel), .force_mdix(force_mdix), .mdix_disable(mdix_disable),
    .fef_detect_en(fef_detect_en), .tx_disable(tx_disable), .adv_ability(adv_ability),
    .op_speed_100(op_speed_100), .op_full_duplex(op_full_duplex));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // expected read value from the shadow copy and the status inputs
  function logic [15:0] exp_rd(input logic [11:0] a);
    logic [15:0] f;
    logic fef;
    fef = st[5] & st[6] & ~m_ctrl[2];
    f = {11'h000, m_adv};
    for (int k = 0; k < 9; k++) f[fp[k]] = m_ctrl[bp[k]];
    case (a)
      12'h058: return m_ctrl;
      12'h05A: return {5'h0F, 5'h00, st[11], fef, 1'b1, st[7], 2'h0};
      12'h080: return f;
      12'h082: return {m_ctrl[5], 6'h00, fef, 1'b0, st[11], st[7], st[4:0]};
      default: return 16'h0000;
    endcase
  endfunction

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task wr(input logic [11:0] a, input logic [15:0] wd);
    logic rs;
    rs = (a == 12'h058 && wd[9]) || (a == 12'h080 && wd[13]);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // shadow copy: only writable bits, restart is not stored
    if (a == 12'h058) m_ctrl = wd & 16'h793E;
    if (a == 12'h080) begin
      for (int k = 0; k < 9; k++) m_ctrl[bp[k]] = wd[fp[k]];
      m_adv = wd[4:0];
    end
    if (a == 12'h082) m_ctrl[5] = wd[15];
    #1;
    chk("restart", {15'h0000, rs}, {15'h0000, an_restart});
  endtask

  task rd(input logic [11:0] a);
    logic [15:0] e;
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    e = exp_rd(a);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask

  // control lines and resolved mode against the shadow copy
  task outs();
    logic [1:0] md;
    md = m_ctrl[12] ? {st[9], st[11] & st[8] & ~st[10]} : {m_ctrl[13], m_ctrl[8]};
    chk("ctrl_out", {1'b0, m_ctrl[14:11], m_ctrl[8], m_ctrl[5:3], m_ctrl[1],
      st[5] & ~m_ctrl[2], m_adv}, {1'b0, far_loopback, force_100, an_enable, power_down,
      force_full, xover_alg_sel, force_mdix, mdix_disable, tx_disable, fef_detect_en,
      adv_ability});
    chk("mode", {14'h0000, md}, {14'h0000, op_speed_100, op_full_duplex});
  endtask

  task final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    st = 12'h000;
    m_ctrl = 16'h3120;
    m_adv = 5'h1F;
    rng = 32'h755CEAB0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(12'h058);
    rd(12'h080);
    outs();
    $display("test reset values done");
    // control bits 1 to 15 each alone, read-only ones included
    for (i = 1; i < 16; i++) begin
      wr(12'h058, 16'h0001 << i);
      rd(12'h058);
      rd(12'h082);
      outs();
    end
    $display("test single bits done");
    // negotiation on but failed, full duplex forced and resolved half
    @(posedge clk_sys);
    st <= 12'hF00;
    wr(12'h058, 16'h1100);
    rd(12'h05A);
    outs();
    wr(12'h058, 16'h2100);
    // the resolved mode is registered, so let it settle before looking
    rd(12'h058);
    outs();
    $display("test failed negotiation done");
    for (i = 0; i < 60; i++) begin
      rng = xs(rng);
      @(posedge clk_sys);
      st <= rng[11:0];
      wr(at[rng[14:12]], rng[31:16]);
      rd(at[rng[17:15]]);
      outs();
    end
    $display("test random traffic done");
    // reset again in mid-run; every stored bit must fall back
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    m_ctrl = 16'h3120;
    m_adv = 5'h1F;
    rd(12'h058);
    rd(12'h080);
    outs();
    $display("test mid-run reset done");
    final_report();
  end
endmodule
